// ---- pkg/logic_cell_consts.svh ----
`ifndef LOGIC_CELL_CONSTS_SVH
`define LOGIC_CELL_CONSTS_SVH

`define LC_ADDR_W        4
`define LC_DATA_W        8
`define LC_CODE_W        6
`define LC_LANES         4
`define LC_SRC_DEFAULT   64

`define LC_OFS_CTRL      4'h0
`define LC_OFS_POL       4'h1
`define LC_OFS_SEL_A     4'h2
`define LC_OFS_SEL_B     4'h3
`define LC_OFS_SEL_C     4'h4
`define LC_OFS_SEL_D     4'h5
`define LC_OFS_GLS_A     4'h6
`define LC_OFS_GLS_B     4'h7

`define LC_CTRL_EN_BIT   7
`define LC_CTRL_OUT_BIT  5
`define LC_POL_OUT_BIT   7
`define LC_CTRL_RESET    1'h0
`define LC_POL_OUT_RESET 1'h0
`define LC_RDATA_IDLE    8'h00

`endif

// ---- pkg/logic_cell_pkg.sv ----
`default_nettype none
`include "logic_cell_consts.svh"

package logic_cell_pkg;
    typedef logic [`LC_DATA_W-1:0] reg_byte_t;
    typedef logic [`LC_CODE_W-1:0] src_code_t;
    typedef logic [`LC_LANES-1:0]  lane_vec_t;
    typedef logic [`LC_ADDR_W-1:0] reg_addr_t;
endpackage

`default_nettype wire

// ---- rtl/logic_cell_input_gating.sv ----
// How it works
// - set top polarity bit inverts cell output
// - gate invert bits flip each gate output
// - polarity bits six to four read zero
// - output invert resets, gate inverts keep value
// - six-bit source code, upper two read zero
// - selects writable, unknown at power-on, kept
// - true and negated bit per lane
// - lane d true on top, a neg lowest
// - disabled cell drives output zero
// - status bit shows output after inversion
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "logic_cell_consts.svh"

module logic_cell_input_gating
    import logic_cell_pkg::*;
#(
    parameter int NUM_SOURCES = `LC_SRC_DEFAULT
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire reg_addr_t              reg_addr,
    input  wire reg_byte_t              reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output var  reg_byte_t              reg_rdata,
    input  wire logic [NUM_SOURCES-1:0] source_in,
    input  wire logic                   logic_func_in,
    input  wire logic                   gate_c_raw,
    input  wire logic                   gate_d_raw,
    output logic                        data_lane_a,
    output logic                        data_lane_b,
    output logic                        data_lane_c,
    output logic                        data_lane_d,
    output logic                        gate_a_out,
    output logic                        gate_b_out,
    output logic                        gate_c_out,
    output logic                        gate_d_out,
    output logic                        cell_output
);

    generate
        if (NUM_SOURCES < 1 || NUM_SOURCES > (1 << `LC_CODE_W)) begin : g_bad_sources
            $error("NUM_SOURCES must lie between 1 and 64");
        end
    endgenerate

    // codes beyond the populated sources read as a quiet zero
    function automatic logic src_pick(input logic [NUM_SOURCES-1:0] srcs, input src_code_t code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_SOURCES; i++) begin
            if (code == src_code_t'(i)) begin
                hit = srcs[i];
            end
        end
        return hit;
    endfunction

    function automatic logic gate_or(input reg_byte_t terms, input lane_vec_t lanes);
        logic acc;
        acc = 1'b0;
        for (int k = 0; k < `LC_LANES; k++) begin
            acc = acc | (terms[2*k+1] & lanes[k]) | (terms[2*k] & ~lanes[k]);
        end
        return acc;
    endfunction

    logic             ctrl_en_r;
    logic             out_inv_r;
    lane_vec_t        gate_inv_r;
    src_code_t        sel_r [`LC_LANES];
    reg_byte_t        gls_a_r;
    reg_byte_t        gls_b_r;
    logic [NUM_SOURCES-1:0] sync_1_r;
    logic [NUM_SOURCES-1:0] sync_2_r;
    logic [NUM_SOURCES-1:0] sync_3_r;
    logic [NUM_SOURCES-1:0] filt_r;
    logic [NUM_SOURCES-1:0] filt_nxt;
    lane_vec_t        lane_r;
    lane_vec_t        lane_nxt;
    lane_vec_t        gate_r;
    logic             cell_out_r;
    reg_byte_t        rdata_r;
    reg_byte_t        rdata_nxt;

    // control register: cleared by every reset
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_en_r <= `LC_CTRL_RESET;
        end else if (reg_wr && reg_addr == `LC_OFS_CTRL) begin
            ctrl_en_r <= reg_wdata[`LC_CTRL_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            out_inv_r <= `LC_POL_OUT_RESET;
        end else if (reg_wr && reg_addr == `LC_OFS_POL) begin
            out_inv_r <= reg_wdata[`LC_POL_OUT_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (reg_wr && reg_addr == `LC_OFS_POL) begin
            gate_inv_r <= reg_wdata[`LC_LANES-1:0];
        end
    end

    always_ff @(posedge clk) begin
        for (int k = 0; k < `LC_LANES; k++) begin
            if (reg_wr && reg_addr == `LC_OFS_SEL_A + reg_addr_t'(k)) begin
                sel_r[k] <= reg_wdata[`LC_CODE_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reg_wr && reg_addr == `LC_OFS_GLS_A) begin
            gls_a_r <= reg_wdata;
        end
        if (reg_wr && reg_addr == `LC_OFS_GLS_B) begin
            gls_b_r <= reg_wdata;
        end
    end

    // sources are asynchronous pins; a bit moves only once stages two and three agree
    always_comb begin
        filt_nxt = (sync_3_r & ~(sync_2_r ^ sync_3_r)) | (filt_r & (sync_2_r ^ sync_3_r));
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sync_1_r <= '0;
            sync_2_r <= '0;
            sync_3_r <= '0;
            filt_r   <= '0;
        end else begin
            sync_1_r <= source_in;
            sync_2_r <= sync_1_r;
            sync_3_r <= sync_2_r;
            filt_r   <= filt_nxt;
        end
    end

    always_comb begin
        for (int k = 0; k < `LC_LANES; k++) begin
            lane_nxt[k] = src_pick(filt_r, sel_r[k]);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lane_r <= '0;
        end else begin
            lane_r <= lane_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            gate_r <= '0;
        end else begin
            gate_r[0] <= gate_or(gls_a_r, lane_r) ^ gate_inv_r[0];
            gate_r[1] <= gate_or(gls_b_r, lane_r) ^ gate_inv_r[1];
            gate_r[2] <= gate_c_raw ^ gate_inv_r[2];
            gate_r[3] <= gate_d_raw ^ gate_inv_r[3];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cell_out_r <= 1'b0;
        end else begin
            cell_out_r <= ctrl_en_r & (logic_func_in ^ out_inv_r);
        end
    end

    always_comb begin
        rdata_nxt = `LC_RDATA_IDLE;
        case (reg_addr)
            `LC_OFS_CTRL: begin
                rdata_nxt[`LC_CTRL_EN_BIT]  = ctrl_en_r;
                rdata_nxt[`LC_CTRL_OUT_BIT] = cell_out_r;
            end
            `LC_OFS_POL: begin
                rdata_nxt[`LC_POL_OUT_BIT]  = out_inv_r;
                rdata_nxt[`LC_LANES-1:0]    = gate_inv_r;
            end
            `LC_OFS_SEL_A: rdata_nxt[`LC_CODE_W-1:0] = sel_r[0];
            `LC_OFS_SEL_B: rdata_nxt[`LC_CODE_W-1:0] = sel_r[1];
            `LC_OFS_SEL_C: rdata_nxt[`LC_CODE_W-1:0] = sel_r[2];
            `LC_OFS_SEL_D: rdata_nxt[`LC_CODE_W-1:0] = sel_r[3];
            `LC_OFS_GLS_A: rdata_nxt = gls_a_r;
            `LC_OFS_GLS_B: rdata_nxt = gls_b_r;
            default:       rdata_nxt = `LC_RDATA_IDLE;
        endcase
    end

    // read data lives for exactly one cycle, zero otherwise
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_r <= `LC_RDATA_IDLE;
        end else if (reg_rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= `LC_RDATA_IDLE;
        end
    end

    assign reg_rdata   = rdata_r;
    assign data_lane_a = lane_r[0];
    assign data_lane_b = lane_r[1];
    assign data_lane_c = lane_r[2];
    assign data_lane_d = lane_r[3];
    assign gate_a_out  = gate_r[0];
    assign gate_b_out  = gate_r[1];
    assign gate_c_out  = gate_r[2];
    assign gate_d_out  = gate_r[3];
    assign cell_output = cell_out_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic past_valid_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            past_valid_r <= 1'b0;
        end else begin
            past_valid_r <= 1'b1;
        end
    end

    // gate invert bits power up unknown, so checks on them wait for a first write
    logic pol_known_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            pol_known_r <= 1'b0;
        end else if (reg_wr && reg_addr == `LC_OFS_POL) begin
            pol_known_r <= 1'b1;
        end
    end

    AST_CELL_INVERT: assert property (
        past_valid_r && ctrl_en_r && !reg_wr |=> cell_output == ($past(logic_func_in) ^ $past(out_inv_r)))
        else $error("cell output does not follow the output invert bit");

    AST_GATE_INVERT: assert property (
        pol_known_r |=> gate_c_out == ($past(gate_c_raw) ^ $past(gate_inv_r[2])))
        else $error("gate c output ignores its invert bit");

    AST_POL_RESERVED: assert property (
        reg_rd && reg_addr == `LC_OFS_POL |=> reg_rdata[6:4] == 3'h0 && reg_rdata[7] == $past(out_inv_r))
        else $error("polarity middle bits not zero on read");

    AST_RESET_INVERT: assert property (
        @(posedge clk) disable iff (1'b0) reset |=> !out_inv_r && !ctrl_en_r && !cell_output)
        else $error("reset did not clear output invert or enable");

    AST_SEL_READ: assert property (
        reg_rd && reg_addr == `LC_OFS_SEL_B |=> reg_rdata == {2'h0, $past(sel_r[1])})
        else $error("source select readback wrong");

    AST_KEEP_RESET: assert property (
        @(posedge clk) disable iff (1'b0) past_valid_r && reset && !reg_wr
        |=> sel_r[0] == $past(sel_r[0]) && gls_a_r == $past(gls_a_r))
        else $error("selection changed across reset");

    AST_TERM_GATE: assert property (
        past_valid_r && gls_a_r == 8'h02 && gate_inv_r[0] == 1'b0 && !reg_wr |=> gate_a_out == $past(lane_r[0]))
        else $error("lane a true term not passed into gate a");

    AST_TERM_ORDER: assert property (
        past_valid_r && gls_b_r == 8'h40 && gate_inv_r[1] == 1'b0 && !reg_wr |=> gate_b_out == !$past(lane_r[3]))
        else $error("lane d negated term not at bit six of gate b");

    AST_DISABLED_ZERO: assert property (
        !ctrl_en_r && !reg_wr ##1 !ctrl_en_r |-> !cell_output)
        else $error("disabled cell drove its output");

    AST_STATUS_BIT: assert property (
        reg_rd && reg_addr == `LC_OFS_CTRL |=> reg_rdata[`LC_CTRL_OUT_BIT] == $past(cell_output))
        else $error("status bit differs from cell output");

    AST_EMPTY_GATE: assert property (
        gls_a_r == 8'h00 && gate_inv_r[0] == 1'b0 && !reg_wr |=> !gate_a_out)
        else $error("gate with no terms is not zero");

    AST_SRC_TABLE: assert property (
        past_valid_r && filt_r == '0 |=> lane_r == 4'h0)
        else $error("lane set with every source low");

    AST_READ_ONE_CYCLE: assert property (
        !reg_rd |=> reg_rdata == `LC_RDATA_IDLE)
        else $error("read data outside the answer cycle");

    AST_GATE_D_INVERT: assert property (
        pol_known_r |=> gate_d_out == ($past(gate_d_raw) ^ $past(gate_inv_r[3])))
        else $error("gate d output ignores its invert bit");

    AST_GATE_FULL: assert property (
        pol_known_r && gls_a_r == 8'hff |=> gate_a_out == !$past(gate_inv_r[0]))
        else $error("gate with every term enabled is not one");

    AST_GATE_B_EMPTY: assert property (
        gls_b_r == 8'h00 && gate_inv_r[1] == 1'b0 |=> !gate_b_out)
        else $error("gate b with no terms is not zero");

    AST_SEL_UPPER_ZERO: assert property (
        reg_rd && reg_addr inside {[`LC_OFS_SEL_A:`LC_OFS_SEL_D]} |=> reg_rdata[7:6] == 2'h0)
        else $error("source select upper bits not zero on read");

    AST_LANE_SELECT: assert property (
        past_valid_r && sel_r[0] == 6'h00 |=> data_lane_a == $past(filt_r[0]))
        else $error("code zero does not pick the first source");

    CVR_ENABLED_HIGH: cover property (ctrl_en_r ##1 cell_output);
    CVR_INVERTED_OUT: cover property (ctrl_en_r && out_inv_r ##1 cell_output ##1 !cell_output);
    CVR_GATE_TOGGLE: cover property (gate_a_out ##1 !gate_a_out ##1 gate_a_out);
    CVR_STATUS_READ: cover property (reg_rd && reg_addr == `LC_OFS_CTRL && cell_output);
    CVR_FULL_GATE: cover property (gls_a_r == 8'hff ##1 gate_a_out);

endmodule // logic_cell_input_gating

`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "logic_cell_consts.svh"

module testbench
    import logic_cell_pkg::*;
;
    logic        clk           = 1'b0;
    logic        reset         = 1'b1;
    reg_addr_t   reg_addr      = '0;
    reg_byte_t   reg_wdata     = '0;
    logic        reg_wr        = 1'b0;
    logic        reg_rd        = 1'b0;
    logic [63:0] source_in     = '0;
    logic        logic_func_in = 1'b0;
    logic        gate_c_raw    = 1'b0;
    logic        gate_d_raw    = 1'b0;
    reg_byte_t   reg_rdata;
    wire  [3:0]  lanes;
    wire  [3:0]  gates;
    wire         cell_output;
    int          bad_count = 0;
    int          n_tests   = 0;
    int          seed      = 62948;
    reg_byte_t   rd;
    reg_byte_t   cell_output_invert;
    reg_byte_t   gls_a;
    reg_byte_t   gls_b;
    reg_byte_t   last [16];
    src_code_t   code [4];
    lane_vec_t   lexp;
    lane_vec_t   gexp;
    logic        en;

    logic_cell_input_gating #(.NUM_SOURCES(64)) uut (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .source_in(source_in), .logic_func_in(logic_func_in),
        .gate_c_raw(gate_c_raw), .gate_d_raw(gate_d_raw), .data_lane_a(lanes[0]), .data_lane_b(lanes[1]),
        .data_lane_c(lanes[2]), .data_lane_d(lanes[3]), .gate_a_out(gates[0]), .gate_b_out(gates[1]),
        .gate_c_out(gates[2]), .gate_d_out(gates[3]), .cell_output(cell_output)
    );

    always #4 clk = ~clk;

    task automatic check(input reg_byte_t seen, input reg_byte_t exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input reg_addr_t a, input reg_byte_t d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // data is only valid in the single cycle after the strobe edge
    task automatic rdr(input reg_addr_t a, output reg_byte_t d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic reg_byte_t rmask(input int a);
        if (a == `LC_OFS_POL) return 8'h8f;
        if (a >= `LC_OFS_SEL_A && a <= `LC_OFS_SEL_D) return 8'h3f;
        if (a == `LC_OFS_GLS_A || a == `LC_OFS_GLS_B) return 8'hff;
        return 8'h00;
    endfunction

    // bit 2k+1 gates lane k true, bit 2k gates it inverted
    function automatic logic gate_fn(input lane_vec_t l, input reg_byte_t g);
        return |(g & {l[3], ~l[3], l[2], ~l[2], l[1], ~l[1], l[0], ~l[0]});
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rdr(`LC_OFS_POL, rd);
        check(rd & 8'h80, 8'h00);
        rdr(`LC_OFS_CTRL, rd);
        check(rd & 8'ha0, 8'h00);
        $display("reset test done");
        for (int a = 1; a < 16; a++) begin
            repeat (3) begin
                last[a] = 8'($random(seed));
                wr(reg_addr_t'(a), last[a]);
                rdr(reg_addr_t'(a), rd);
                check(rd, last[a] & rmask(a));
            end
        end
        $display("register test done");
        // a later reset keeps selects, clears output invert
        last[`LC_OFS_POL] = last[`LC_OFS_POL] | 8'h80;
        wr(`LC_OFS_POL, last[`LC_OFS_POL]);
        wr(`LC_OFS_CTRL, 8'h80);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        for (int a = 1; a < 8; a++) begin
            rdr(reg_addr_t'(a), rd);
            check(rd, last[a] & rmask(a) & ((a == `LC_OFS_POL) ? 8'h0f : 8'hff));
        end
        rdr(`LC_OFS_CTRL, rd);
        check(rd & 8'h80, 8'h00);
        $display("second reset test done");
        for (int i = 0; i < 40; i++) begin
            for (int k = 0; k < 4; k++) begin
                code[k] = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
                wr(reg_addr_t'(`LC_OFS_SEL_A + k), {2'b00, code[k]});
            end
            gls_a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            gls_b = 8'($random(seed));
            cell_output_invert = 8'($random(seed));
            en = (i % 3 != 0);
            wr(`LC_OFS_GLS_A, gls_a);
            wr(`LC_OFS_GLS_B, gls_b);
            wr(`LC_OFS_POL, cell_output_invert);
            wr(`LC_OFS_CTRL, {en, 7'h00});
            @(posedge clk);
            source_in <= {$random(seed), $random(seed)};
            logic_func_in <= 1'($random(seed));
            gate_c_raw <= 1'($random(seed));
            gate_d_raw <= 1'($random(seed));
            // sync chain needs six edges, allow a margin
            repeat (8) @(posedge clk);
            #1;
            for (int k = 0; k < 4; k++) begin
                lexp[k] = source_in[code[k]];
            end
            check({4'h0, lanes}, {4'h0, lexp});
            gexp = {gate_d_raw, gate_c_raw, gate_fn(lexp, gls_b), gate_fn(lexp, gls_a)} ^ cell_output_invert[3:0];
            check({4'h0, gates}, {4'h0, gexp});
            check({7'h0, cell_output}, {7'h0, en & (logic_func_in ^ cell_output_invert[7])});
            rdr(`LC_OFS_CTRL, rd);
            check(rd & 8'ha0, {en, 1'b0, en & (logic_func_in ^ cell_output_invert[7]), 5'h00});
        end
        $display("data path test done");
        summarize();
    end
endmodule // testbench
`default_nettype wire
